// ---- rtl/psw_swap_pkg.sv ----
// Constants and types shared by the interruption status-swap logic.
package psw_swap_pkg;
  localparam int ADDR_W = 24;
  // Preferential-area offsets relative to the element's base.
  localparam logic [7:0] OFF_IPL_SDW = 8'h00;
  localparam logic [7:0] OFF_IPL_CCW1 = 8'h08;
  localparam logic [7:0] OFF_IPL_CCW2 = 8'h10;
  localparam logic [7:0] OFF_OLD_EXT = 8'h18;
  localparam logic [7:0] OFF_OLD_SVC = 8'h20;
  localparam logic [7:0] OFF_OLD_PRG = 8'h28;
  localparam logic [7:0] OFF_OLD_MCK = 8'h30;
  localparam logic [7:0] OFF_OLD_IO = 8'h38;
  localparam logic [7:0] OFF_CSW = 8'h40;
  localparam logic [7:0] OFF_CAW = 8'h48;
  localparam logic [7:0] OFF_TIMER = 8'h50;
  localparam logic [7:0] OFF_NEW_EXT = 8'h58;
  localparam logic [7:0] OFF_NEW_SVC = 8'h60;
  localparam logic [7:0] OFF_NEW_PRG = 8'h68;
  localparam logic [7:0] OFF_NEW_MCK = 8'h70;
  localparam logic [7:0] OFF_NEW_IO = 8'h78;
  localparam logic [7:0] OFF_LOGOUT = 8'h80;
  // Field positions; doubleword bit n sits at vector index 63-n.
  localparam int SYS_MASK_MSB = 63;
  localparam int EXT_MASK_BIT = 56;
  localparam int PKEY_LSB = 52;
  localparam int MCK_MASK_BIT = 50;
  localparam int ICODE_LSB = 32;
  localparam int ILC_LSB = 30;
  localparam int PMASK_LSB = 24;
  // Interruption codes, length codes and base addresses.
  localparam logic [11:0] CODE_PROT = 12'h004;
  localparam logic [11:0] CODE_ADDR = 12'h005;
  localparam logic [11:0] CODE_SPEC = 12'h006;
  localparam logic [11:0] CODE_FXOVF = 12'h008;
  localparam logic [11:0] CODE_DCOVF = 12'h00a;
  localparam logic [11:0] CODE_EXPUF = 12'h00d;
  localparam logic [11:0] CODE_SIGNF = 12'h00e;
  localparam logic [1:0] ILC_NONE = 2'h0;
  localparam logic [1:0] ILC_SVC = 2'h1;
  localparam logic [23:0] BASE_RESET = 24'h000000;
  localparam logic [23:0] BASE_ALT = 24'h001000;
  // Interruption classes in priority order, highest first.
  typedef enum logic [2:0] {
    CLS_MCK = 3'h0,
    CLS_PRG = 3'h1,
    CLS_SVC = 3'h2,
    CLS_EXT = 3'h3,
    CLS_IO = 3'h4
  } class_e;
  typedef enum logic [5:0] {
    ST_IPL = 6'h01,
    ST_IDLE = 6'h02,
    ST_OLD = 6'h04,
    ST_CSW = 6'h08,
    ST_NEW = 6'h10,
    ST_STOP = 6'h20
  } state_e;
endpackage : psw_swap_pkg

// ---- rtl/display_exc_check.sv ----
// Protection and alignment checks of the display instructions.
`timescale 1ns/1ps
`default_nettype none
module display_exc_check (
  input  wire logic        key_check,
  input  wire logic [3:0]  storage_key,
  input  wire logic [3:0]  prot_key,
  input  wire logic        chain_load,
  input  wire logic [23:0] chain_load_addr,
  input  wire logic        page_chain,
  input  wire logic [63:0] page_chain_dw,
  input  wire logic        repack_start,
  input  wire logic [23:0] old_refresh_pointer,
  input  wire logic [23:0] new_refresh_pointer,
  output logic             prot_exc,
  output logic             spec_exc
);
  logic chain_bad;
  logic page_bad;
  logic repack_bad;

  // Key zero on either side is a master key.
  assign prot_exc = key_check && (storage_key != prot_key)
                    && (storage_key != 4'h0) && (prot_key != 4'h0);
  assign chain_bad = chain_load && (chain_load_addr[2:0] != 3'h0);
  // The chain address sits in bytes 5-7 of the word after the page.
  assign page_bad = page_chain && (page_chain_dw[2:0] != 3'h0);
  assign repack_bad = repack_start && ((old_refresh_pointer[2:0] != 3'h0)
                      || (new_refresh_pointer[2:0] != 3'h0));
  assign spec_exc = chain_bad || page_bad || repack_bad;
endmodule : display_exc_check
`default_nettype wire

// ---- rtl/interruption_psw_swap_unit.sv ----
// Interruption action: status-doubleword swap through the preferential area.
`timescale 1ns/1ps
`default_nettype none
module interruption_psw_swap_unit (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        instr_done,
  input  wire logic        long_point,
  input  wire logic [1:0]  instr_len,
  input  wire logic [23:0] next_ia,
  input  wire logic        stop_cmd,
  input  wire logic        io_req,
  input  wire logic [2:0]  io_chan,
  input  wire logic [11:0] io_code,
  input  wire logic [63:0] channel_status_doubleword,
  input  wire logic        ext_req,
  input  wire logic [11:0] ext_code,
  input  wire logic        mchk_req,
  input  wire logic        svc_req,
  input  wire logic [11:0] svc_code,
  input  wire logic        prog_req,
  input  wire logic [11:0] prog_code,
  input  wire logic        ilc_unavail,
  input  wire logic        acc_fail,
  input  wire logic        acc_fail_check,
  input  wire logic        key_check,
  input  wire logic [3:0]  storage_key,
  input  wire logic        prot_store,
  input  wire logic        chain_load,
  input  wire logic [23:0] chain_load_addr,
  input  wire logic        page_chain,
  input  wire logic [63:0] page_chain_dw,
  input  wire logic        repack_start,
  input  wire logic [23:0] old_refresh_pointer,
  input  wire logic [23:0] new_refresh_pointer,
  input  wire logic        load_base,
  input  wire logic [23:0] base_in,
  input  wire logic        inhibit_logout_stop,
  output logic             mem_req,
  output logic             mem_we,
  output logic [23:0]      mem_addr,
  output logic [63:0]      mem_wdata,
  input  wire logic [63:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  output logic [63:0]      status_doubleword,
  output logic             busy,
  output logic             stopped,
  output logic             suppress_results,
  output logic             terminate_results,
  output logic             element_check_signal,
  output logic             check_stop
);
  psw_swap_pkg::state_e state_r;
  psw_swap_pkg::class_e cls_r;
  psw_swap_pkg::class_e cls_nxt;
  logic [63:0] sdw_r;
  logic [63:0] old_sdw_r;
  logic [23:0] base_r;
  logic        alt_r;
  logic        io_pend_r;
  logic        ext_pend_r;
  logic        mck_pend_r;
  logic        svc_pend_r;
  logic        prg_pend_r;
  logic [11:0] io_code_r;
  logic [11:0] ext_code_r;
  logic [11:0] svc_code_r;
  logic [11:0] prg_code_r;
  logic        prg_ilc0_r;
  logic        suppress_r;
  logic        terminate_r;
  logic        stopped_r;
  logic        elc_r;
  logic        prot_exc;
  logic        spec_exc;
  logic        boundary;
  logic        take;
  logic        mck_ok;
  logic        ext_ok;
  logic        io_ok;
  logic        prg_det;
  logic [11:0] prg_det_code;
  logic        prg_masked;
  logic        fail_ok;
  logic        mem_done;
  logic [7:0]  off;
  logic [11:0] icode;
  logic [1:0]  ilc;

  display_exc_check chk (
    .key_check           (key_check),
    .storage_key         (storage_key),
    .prot_key            (sdw_r[psw_swap_pkg::PKEY_LSB+:4]),
    .chain_load          (chain_load),
    .chain_load_addr     (chain_load_addr),
    .page_chain          (page_chain),
    .page_chain_dw       (page_chain_dw),
    .repack_start        (repack_start),
    .old_refresh_pointer (old_refresh_pointer),
    .new_refresh_pointer (new_refresh_pointer),
    .prot_exc            (prot_exc),
    .spec_exc            (spec_exc)
  );

  // Mask gating per class; the I/O channel picks a system mask bit.
  assign mck_ok = mck_pend_r && sdw_r[psw_swap_pkg::MCK_MASK_BIT];
  assign ext_ok = ext_pend_r && sdw_r[psw_swap_pkg::EXT_MASK_BIT];
  assign io_ok = io_pend_r && sdw_r[psw_swap_pkg::SYS_MASK_MSB - io_chan];
  // Long instructions offer interruption points inside their run.
  assign boundary = (instr_done || long_point) && (state_r == psw_swap_pkg::ST_IDLE);
  assign take = boundary && (mck_ok || prg_pend_r || svc_pend_r || ext_ok || io_ok);
  assign fail_ok = !alt_r && !inhibit_logout_stop;
  assign mem_done = mem_req && (mem_ack || mem_err);

  always_comb begin
    if (mck_ok) begin
      cls_nxt = psw_swap_pkg::CLS_MCK;
    end else if (prg_pend_r) begin
      cls_nxt = psw_swap_pkg::CLS_PRG;
    end else if (svc_pend_r) begin
      cls_nxt = psw_swap_pkg::CLS_SVC;
    end else if (ext_ok) begin
      cls_nxt = psw_swap_pkg::CLS_EXT;
    end else begin
      cls_nxt = psw_swap_pkg::CLS_IO;
    end
  end

  // Program causes found during the instruction, first one wins.
  always_comb begin
    prg_det = 1'b1;
    if (spec_exc) begin
      prg_det_code = psw_swap_pkg::CODE_SPEC;
    end else if (prot_exc) begin
      prg_det_code = psw_swap_pkg::CODE_PROT;
    end else if (acc_fail && !acc_fail_check && fail_ok) begin
      prg_det_code = psw_swap_pkg::CODE_ADDR;
    end else begin
      prg_det = prog_req;
      prg_det_code = prog_code;
    end
  end

  // Four causes are gated by the program mask and are then dropped.
  always_comb begin
    unique case (prg_det_code)
      psw_swap_pkg::CODE_FXOVF: prg_masked = !sdw_r[psw_swap_pkg::PMASK_LSB+3];
      psw_swap_pkg::CODE_DCOVF: prg_masked = !sdw_r[psw_swap_pkg::PMASK_LSB+2];
      psw_swap_pkg::CODE_EXPUF: prg_masked = !sdw_r[psw_swap_pkg::PMASK_LSB+1];
      psw_swap_pkg::CODE_SIGNF: prg_masked = !sdw_r[psw_swap_pkg::PMASK_LSB];
      default: prg_masked = 1'b0;
    endcase
  end

  // Slot offsets per class; every address adds the current base.
  always_comb begin
    off = psw_swap_pkg::OFF_IPL_SDW;
    unique case (1'b1)
      state_r[2]: begin
        unique case (cls_r)
          psw_swap_pkg::CLS_EXT: off = psw_swap_pkg::OFF_OLD_EXT;
          psw_swap_pkg::CLS_SVC: off = psw_swap_pkg::OFF_OLD_SVC;
          psw_swap_pkg::CLS_PRG: off = psw_swap_pkg::OFF_OLD_PRG;
          psw_swap_pkg::CLS_MCK: off = psw_swap_pkg::OFF_OLD_MCK;
          default: off = psw_swap_pkg::OFF_OLD_IO;
        endcase
      end
      state_r[3]: off = psw_swap_pkg::OFF_CSW;
      state_r[4]: begin
        unique case (cls_r)
          psw_swap_pkg::CLS_EXT: off = psw_swap_pkg::OFF_NEW_EXT;
          psw_swap_pkg::CLS_SVC: off = psw_swap_pkg::OFF_NEW_SVC;
          psw_swap_pkg::CLS_PRG: off = psw_swap_pkg::OFF_NEW_PRG;
          psw_swap_pkg::CLS_MCK: off = psw_swap_pkg::OFF_NEW_MCK;
          default: off = psw_swap_pkg::OFF_NEW_IO;
        endcase
      end
      default: off = psw_swap_pkg::OFF_IPL_SDW;
    endcase
  end

  assign mem_req = state_r[0] || state_r[2] || state_r[3] || state_r[4];
  assign mem_we = state_r[2] || state_r[3];
  assign mem_addr = base_r + {16'h0000, off};
  assign mem_wdata = state_r[3] ? channel_status_doubleword : old_sdw_r;

  // Code and length of the class being taken.
  always_comb begin
    unique case (cls_nxt)
      psw_swap_pkg::CLS_PRG: icode = prg_code_r;
      psw_swap_pkg::CLS_SVC: icode = svc_code_r;
      psw_swap_pkg::CLS_EXT: icode = ext_code_r;
      psw_swap_pkg::CLS_IO: icode = io_code_r;
      default: icode = 12'h000;
    endcase
    if (cls_nxt == psw_swap_pkg::CLS_SVC) begin
      ilc = psw_swap_pkg::ILC_SVC;
    end else if (cls_nxt == psw_swap_pkg::CLS_PRG && prg_ilc0_r) begin
      ilc = psw_swap_pkg::ILC_NONE;
    end else begin
      ilc = instr_len;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= psw_swap_pkg::ST_IPL;
      cls_r <= psw_swap_pkg::CLS_MCK;
      old_sdw_r <= 64'h0;
    end else begin
      unique case (state_r)
        psw_swap_pkg::ST_IPL: begin
          if (mem_err) begin
            state_r <= psw_swap_pkg::ST_STOP;
          end else if (mem_ack) begin
            state_r <= psw_swap_pkg::ST_IDLE;
          end
        end
        psw_swap_pkg::ST_IDLE: begin
          if (acc_fail && !fail_ok) begin
            state_r <= psw_swap_pkg::ST_STOP;
          end else if (take) begin
            cls_r <= cls_nxt;
            old_sdw_r <= sdw_r;
            old_sdw_r[psw_swap_pkg::ICODE_LSB+:12] <= icode;
            old_sdw_r[psw_swap_pkg::ILC_LSB+:2] <= ilc;
            old_sdw_r[23:0] <= next_ia;
            state_r <= psw_swap_pkg::ST_OLD;
          end
        end
        psw_swap_pkg::ST_OLD, psw_swap_pkg::ST_CSW, psw_swap_pkg::ST_NEW: begin
          if (mem_err) begin
            // A failed swap keeps its request and restarts via the alternate if fail_ok, else stops.
            state_r <= fail_ok ? psw_swap_pkg::ST_OLD : psw_swap_pkg::ST_STOP;
          end else if (mem_ack && state_r == psw_swap_pkg::ST_OLD) begin
            state_r <= (cls_r == psw_swap_pkg::CLS_IO) ? psw_swap_pkg::ST_CSW : psw_swap_pkg::ST_NEW;
          end else if (mem_ack && state_r == psw_swap_pkg::ST_CSW) begin
            state_r <= psw_swap_pkg::ST_NEW;
          end else if (mem_ack) begin
            state_r <= psw_swap_pkg::ST_IDLE;
          end
        end
        psw_swap_pkg::ST_STOP: state_r <= psw_swap_pkg::ST_STOP;
        default: state_r <= psw_swap_pkg::ST_STOP;
      endcase
    end
  end

  // New doubleword becomes current as fetched, with no checking.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sdw_r <= 64'h0;
    end else if ((state_r[4] || state_r[0]) && mem_ack && !mem_err) begin
      sdw_r <= mem_rdata;
    end
  end

  // Base is loaded by software or swapped silently to the alternate.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      base_r <= psw_swap_pkg::BASE_RESET;
      alt_r <= 1'b0;
    end else if (fail_ok && ((mem_done && mem_err && !state_r[0])
                 || (state_r[1] && acc_fail))) begin
      base_r <= psw_swap_pkg::BASE_ALT;
      alt_r <= 1'b1;
    end else if (load_base) begin
      base_r <= base_in;
      alt_r <= 1'b0;
    end
  end

  // Sticky requests; a new request in the taking cycle survives.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      io_pend_r <= 1'b0;
      ext_pend_r <= 1'b0;
      mck_pend_r <= 1'b0;
      svc_pend_r <= 1'b0;
      io_code_r <= 12'h000;
      ext_code_r <= 12'h000;
      svc_code_r <= 12'h000;
    end else begin
      io_pend_r <= io_req || (io_pend_r && !(take && cls_nxt == psw_swap_pkg::CLS_IO));
      ext_pend_r <= ext_req || (ext_pend_r && !(take && cls_nxt == psw_swap_pkg::CLS_EXT));
      mck_pend_r <= mchk_req || (acc_fail && acc_fail_check && fail_ok)
                    || (mck_pend_r && !(take && cls_nxt == psw_swap_pkg::CLS_MCK));
      svc_pend_r <= svc_req || (svc_pend_r && !(take && cls_nxt == psw_swap_pkg::CLS_SVC));
      if (io_req) begin
        io_code_r <= io_code;
      end
      if (ext_req) begin
        ext_code_r <= ext_code;
      end
      if (svc_req) begin
        svc_code_r <= svc_code;
      end
    end
  end

  // Program causes do not stay pending when masked off.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prg_pend_r <= 1'b0;
      prg_code_r <= 12'h000;
      prg_ilc0_r <= 1'b0;
    end else if (prg_det && !prg_masked && state_r[1]) begin
      prg_pend_r <= 1'b1;
      prg_code_r <= prg_det_code;
      prg_ilc0_r <= ilc_unavail && (prot_exc || prg_det_code == psw_swap_pkg::CODE_ADDR);
    end else if (take && cls_nxt == psw_swap_pkg::CLS_PRG) begin
      prg_pend_r <= 1'b0;
    end
  end

  // Specification and store protection suppress; fetch faults terminate.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      suppress_r <= 1'b0;
      terminate_r <= 1'b0;
    end else begin
      suppress_r <= spec_exc || (prot_exc && prot_store);
      terminate_r <= !spec_exc && ((prot_exc && !prot_store)
                     || (acc_fail && !acc_fail_check && fail_ok));
    end
  end

  // Stop is reached only once nothing unmasked is left to take.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stopped_r <= 1'b0;
    end else if (!stop_cmd) begin
      stopped_r <= 1'b0;
    end else if (instr_done && state_r[1] && !take) begin
      stopped_r <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      elc_r <= 1'b0;
    end else if (state_r[1] ? (acc_fail && !fail_ok) : (mem_done && mem_err && !fail_ok)) begin
      elc_r <= 1'b1;
    end
  end

  assign status_doubleword = sdw_r;
  assign busy = !state_r[1];
  assign stopped = stopped_r;
  assign suppress_results = suppress_r;
  assign terminate_results = terminate_r;
  assign element_check_signal = elc_r;
  assign check_stop = state_r[5];

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_prot_raise: assert property (chk.prot_exc && state_r[1] |=> prg_pend_r)
    else $error("protection exception not made pending");
  a_spec_suppress: assert property (spec_exc |=> suppress_results && !terminate_results)
    else $error("specification did not suppress");
  a_take_stores: assert property (take && !(acc_fail && !fail_ok) |=> mem_req && mem_we && state_r[2])
    else $error("taking did not start old store");
  a_new_loads: assert property (state_r[4] && mem_ack && !mem_err |=> sdw_r == $past(mem_rdata) && state_r[1])
    else $error("new doubleword not loaded");
  a_old_addr: assert property (state_r[2] && cls_r == psw_swap_pkg::CLS_PRG |-> mem_addr == base_r + 24'h000028)
    else $error("program old slot address wrong");
  a_new_addr: assert property (state_r[4] && cls_r == psw_swap_pkg::CLS_IO |-> mem_addr == base_r + 24'h000078)
    else $error("io new slot address wrong");
  a_svc_ilc: assert property (take && !(acc_fail && !fail_ok) && cls_nxt == psw_swap_pkg::CLS_SVC
                              |=> old_sdw_r[31:30] == 2'h1)
    else $error("svc length code not one");
  a_no_mid_take: assert property (!instr_done && !long_point |-> !take)
    else $error("taken outside a boundary");
  a_masked_ext: assert property (take && !mck_pend_r && !prg_pend_r && !svc_pend_r && !io_pend_r
                                 |-> sdw_r[56])
    else $error("masked external taken");
  a_alt_switch: assert property (mem_done && mem_err && fail_ok && !state_r[0] |=> base_r == psw_swap_pkg::BASE_ALT
                                 && state_r[2])
    else $error("alternate switch missing");
  a_alt_fail: assert property (mem_done && mem_err && !fail_ok |=> check_stop && element_check_signal)
    else $error("alternate failure did not check stop");
endmodule : interruption_psw_swap_unit
`default_nettype wire

// ---- tb/psa_memory_model.sv ----
// Storage model holding the preferential area, answering every third access, from the second on, one cycle late.
`timescale 1ns/1ps
`default_nettype none
module psa_memory_model #(
  parameter logic [63:0] IPL_WORD = 64'h0,
  parameter logic [63:0] NEW_WORD = 64'h0
) (
  input  wire logic        clock,
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_addr,
  input  wire logic        fail_en,
  output logic [63:0]      mem_rdata,
  output logic             mem_ack,
  output logic             mem_err
);
  logic [1:0] wait_r;
  initial begin
    {mem_rdata, mem_ack, mem_err, wait_r} = '0;
  end
  // Read data toggles while no answer is given, so stale data never looks valid.
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_err <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack && !mem_err) begin
      wait_r <= wait_r + 2'h1;
      if (wait_r != 2'h1) begin
        mem_ack <= !fail_en;
        mem_err <= fail_en;
        mem_rdata <= (mem_addr[7:0] == 8'h00) ? IPL_WORD : NEW_WORD;
      end
    end
  end
endmodule : psa_memory_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench of the interruption status-swap unit.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [63:0] IPL_WORD = 64'h0000_0000_0000_0abc;
  localparam logic [63:0] NEW_WORD = 64'hff34_0000_0f00_0000;
  logic        clock, sys_rst, instr_done, long_point, stop_cmd, io_req, ext_req, svc_req, prog_req, ilc_unavail;
  logic        key_check, prot_store, chain_load, page_chain, repack_start, load_base, fail_en, mem_req, mem_we;
  logic        mem_ack, mem_err, busy, stopped, suppress_results, terminate_results, element_check_signal, check_stop;
  logic        mchk_req;
  logic [1:0]  instr_len;
  logic [2:0]  io_chan;
  logic [3:0]  storage_key;
  logic [11:0] io_code, ext_code, svc_code;
  logic [23:0] next_ia, chain_load_addr, old_refresh_pointer, new_refresh_pointer, base_in, mem_addr, cur_base;
  logic [63:0] channel_status_doubleword, page_chain_dw, mem_rdata, mem_wdata, status_doubleword, prev_sd, got;
  int          n_mismatch, samples_checked;
  interruption_psw_swap_unit interruption_psw_swap_unit_inst (
    .clock, .sys_rst, .instr_done, .long_point, .instr_len, .next_ia, .stop_cmd, .io_req, .io_chan, .io_code,
    .channel_status_doubleword, .ext_req, .ext_code, .mchk_req, .svc_req, .svc_code, .prog_req,
    .prog_code(psw_swap_pkg::CODE_FXOVF), .ilc_unavail, .acc_fail(1'b0), .acc_fail_check(1'b0), .key_check,
    .storage_key, .prot_store, .chain_load, .chain_load_addr, .page_chain, .page_chain_dw, .repack_start,
    .old_refresh_pointer, .new_refresh_pointer, .load_base, .base_in, .inhibit_logout_stop(1'b0), .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .mem_err, .status_doubleword, .busy, .stopped,
    .suppress_results, .terminate_results, .element_check_signal, .check_stop
  );
  psa_memory_model #(.IPL_WORD(IPL_WORD), .NEW_WORD(NEW_WORD)) psa_memory_model_inst (
    .clock, .mem_req, .mem_addr, .fail_en, .mem_rdata, .mem_ack, .mem_err
  );
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic cmp_val(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_val
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // Waits for an answered storage access and checks where it went.
  task automatic acc(input logic [7:0] off, input logic we);
    int k;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (!(mem_req === 1'b1 && (mem_ack === 1'b1 || mem_err === 1'b1)) && k < 60);
    if (k >= 60) begin
      $display("mismatch at %0t: no storage answer", $time);
      n_mismatch++;
      complete_run();
    end
    cmp_val(mem_addr, cur_base + off);
    cmp_val(mem_we, we);
    got = mem_wdata;
  endtask : acc
  task automatic boundary(input int n);
    repeat (n) @(posedge clock);
    instr_done <= 1'b1;
    @(posedge clock);
    instr_done <= 1'b0;
  endtask : boundary
  task automatic req(input int w);
    @(posedge clock);
    {prog_req, mchk_req, svc_req, ext_req, io_req} <= 5'h1 << w;
    @(posedge clock);
    {prog_req, mchk_req, svc_req, ext_req, io_req} <= 5'h0;
    boundary(0);
  endtask : req
  // A length code with bit 2 set is not predictable and is not compared.
  task automatic swap(input logic [7:0] off, input logic [11:0] code, input logic [2:0] ilc, input logic io);
    prev_sd = status_doubleword;
    acc(off, 1'b1);
    cmp_val(got[63:44], prev_sd[63:44]);
    cmp_val(got[43:32], code);
    if (!ilc[2]) cmp_val(got[31:30], ilc[1:0]);
    cmp_val(got[23:0], next_ia);
    if (io) acc(8'h40, 1'b1);
    if (io) cmp_val(got, channel_status_doubleword);
    acc(off + 8'h40, 1'b0);
    @(negedge clock);
    cmp_val(busy, 1'b0);
    cmp_val(status_doubleword, NEW_WORD);
  endtask : swap
  initial begin
    {instr_done, long_point, stop_cmd, io_req, ext_req, svc_req, prog_req, ilc_unavail, key_check, mchk_req} = '0;
    {prot_store, chain_load, page_chain, repack_start, load_base, fail_en, n_mismatch, samples_checked} = '0;
    {instr_len, io_chan, storage_key, cur_base, page_chain_dw} = {2'h3, 3'h2, 4'h5, 24'h0, 64'h104};
    {io_code, ext_code, svc_code, next_ia} = {12'h2c1, 12'h040, 12'h0a5, 24'h00a468};
    {chain_load_addr, old_refresh_pointer, new_refresh_pointer, base_in} = {24'h804, 24'h1004, 24'h3000, 24'h2000};
    channel_status_doubleword = 64'h1234_5678_9abc_def0;
    sys_rst = 1'b1;
    repeat (4) @(posedge clock);
    cmp_val({mem_req, mem_we, mem_addr}, {2'h2, 24'h0});
    sys_rst <= 1'b0;
    acc(8'h00, 1'b0);
    @(negedge clock);
    cmp_val(status_doubleword, IPL_WORD);
    req(0);
    req(4);
    repeat (2) @(negedge clock);
    cmp_val(busy, 1'b0);
    req(2);
    swap(8'h20, svc_code, {1'b0, psw_swap_pkg::ILC_SVC}, 1'b0);
    @(posedge clock);
    long_point <= 1'b1;
    @(posedge clock);
    long_point <= 1'b0;
    swap(8'h38, io_code, 3'h4, 1'b1);
    $display("mask and class test done");
    @(posedge clock);
    load_base <= 1'b1;
    @(posedge clock);
    load_base <= 1'b0;
    cur_base = 24'h002000;
    req(1);
    swap(8'h18, ext_code, 3'h4, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      storage_key <= (i < 2) ? 4'h5 : 4'(i * 3 - 6);
      prot_store <= (i != 1);
      key_check <= 1'b1;
      ilc_unavail <= 1'b1;
      @(posedge clock);
      key_check <= 1'b0;
      @(negedge clock);
      cmp_val({suppress_results, terminate_results}, {i == 0, i == 1});
      boundary(2);
      if (i < 2) swap(8'h28, psw_swap_pkg::CODE_PROT, {1'b0, psw_swap_pkg::ILC_NONE}, 1'b0);
      repeat (2) @(negedge clock);
      cmp_val(busy, 1'b0);
    end
    $display("protection test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      {chain_load, page_chain, repack_start, prog_req} <= 4'h8 >> i;
      ilc_unavail <= 1'b0;
      @(posedge clock);
      {chain_load, page_chain, repack_start, prog_req} <= 4'h0;
      @(negedge clock);
      cmp_val({suppress_results, terminate_results}, {i < 3, 1'b0});
      boundary(2);
      swap(8'h28, (i == 3) ? psw_swap_pkg::CODE_FXOVF : psw_swap_pkg::CODE_SPEC, 3'h3, 1'b0);
    end
    $display("specification test done");
    req(3);
    swap(8'h30, 12'h000, 3'h4, 1'b0);
    @(posedge clock);
    stop_cmd <= 1'b1;
    req(1);
    swap(8'h18, ext_code, 3'h4, 1'b0);
    boundary(1);
    repeat (2) @(negedge clock);
    cmp_val(stopped, 1'b1);
    @(posedge clock);
    stop_cmd <= 1'b0;
    fail_en <= 1'b1;
    req(2);
    acc(8'h20, 1'b1);
    @(posedge clock);
    fail_en <= 1'b0;
    cur_base = psw_swap_pkg::BASE_ALT;
    swap(8'h20, svc_code, {1'b0, psw_swap_pkg::ILC_SVC}, 1'b0);
    cmp_val(element_check_signal, 1'b0);
    @(posedge clock);
    fail_en <= 1'b1;
    req(2);
    for (int k = 0; k < 60 && check_stop !== 1'b1; k++) @(negedge clock);
    cmp_val({check_stop, element_check_signal}, 2'h3);
    $display("alternate area test done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
